// ==== rtl/sptr_pkg.sv ====
// Package: register map, field layout, reset values and access masks
`default_nettype none
package sptr_pkg;

	// Register byte offsets within the port's configuration space
	localparam logic [7:0] OFF_PHY_TUNING_WORD_FOUR = 8'h84;
	localparam logic [7:0] OFF_LINK_CONTROL_WORD_FIVE = 8'h88;
	localparam logic [7:0] OFF_TRANSACTION_LAYER_CONTROL = 8'h8c;
	localparam logic [7:0] OFF_PHY_LANE_AND_DELTA_PARAMS = 8'h90;

	// Field positions in link_control_word_five
	localparam int LCW_CFG_KEEP_BIT = 11;
	localparam int LCW_RATE_CHANGE_BIT = 30;
	localparam int LCW_GEN1_ONLY_BIT = 31;

	// Field positions in transaction_layer_control
	localparam int TLC_FRAME_START_FORM_BIT = 0;
	localparam int TLC_PM_DATA_SEL_BIT = 1;
	localparam int TLC_ARB_ABORT_BIT = 2;
	localparam int TLC_BOUNDARY_4K_BIT = 3;
	localparam int TLC_QUEUE_ERR_FIX_BIT = 4;
	localparam int TLC_MW_OVERPASS_DIS_BIT = 5;
	localparam int TLC_ORDERING_DIS_BIT = 6;
	localparam int TLC_GRANT_FAIL_IDLE_BIT = 7;
	localparam int TLC_RATE_ATTEMPT_LSB = 8;
	localparam int TLC_PORT_DISABLE_BIT = 10;
	localparam int TLC_RESET_SELECT_BIT = 11;
	localparam int TLC_ARB_CHAN_FLAG_BIT = 12;
	localparam int TLC_RETRAIN_CTRL_LSB = 16;
	localparam int TLC_REV_TS_LSB = 24;
	localparam int TLC_MAC_CTRL_LSB = 26;
	localparam int TLC_GEN2_PHY_MODE_BIT = 31;

	// Field positions in phy_lane_and_delta_params
	localparam int PLD_LANE_MODE_LSB = 0;
	localparam int PLD_DELTA_LSB = 15;

	// Reset values
	localparam logic [31:0] RST_PHY_TUNING_WORD_FOUR = 32'h0000_0000;
	localparam logic [31:0] RST_LCW_UPSTREAM = 32'h7308_3333;
	localparam logic [31:0] RST_LCW_DOWNSTREAM = 32'h3308_3333;
	localparam logic [31:0] RST_TRANSACTION_LAYER_CONTROL = 32'h0079_1894;
	localparam logic [31:0] RST_PHY_LANE_AND_DELTA = 32'h0000_8000;

	// Software-writable bits (configuration write)
	localparam logic [31:0] CFG_WR_LCW = 32'hc000_0000;
	localparam logic [31:0] CFG_WR_TLC_UP = 32'h0000_0060;

	// Sideband-overridable bits, any port / upstream port only
	localparam logic [31:0] SB_ANY_PTW = 32'h0000_0000;
	localparam logic [31:0] SB_UP_PTW = 32'hffff_ffff;
	localparam logic [31:0] SB_ANY_LCW = 32'hc000_0000;
	localparam logic [31:0] SB_UP_LCW = 32'h3fff_ffff;
	localparam logic [31:0] SB_ANY_TLC = 32'h83ff_0f00;
	localparam logic [31:0] SB_UP_TLC = 32'h3c00_10af;
	localparam logic [31:0] SB_EE_UP_TLC = 32'h0000_0040;
	localparam logic [31:0] SB_ANY_PLD = 32'h0000_007f;
	localparam logic [31:0] SB_UP_PLD = 32'hffff_8000;

	// Source of a sideband default override
	typedef enum logic [1:0] {
		SPTR_SRC_SMBUS = 2'h0,
		SPTR_SRC_I2C = 2'h1,
		SPTR_SRC_EEPROM = 2'h2
	} sptr_src_t;

	// One register access request
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} sptr_req_t;

	// Tuning fields the port logic consumes
	typedef struct packed {
		logic cfg_keep_on_link_down;
		logic rate_change_ctrl;
		logic gen1_only;
		logic mw_overpass_dis;
		logic ordering_dis;
		logic [1:0] rate_change_attempts;
		logic port_disable;
		logic reset_select;
		logic retrain_on_phy_err_dis;
	} sptr_ctrl_t;

endpackage : sptr_pkg
`default_nettype wire

// ==== rtl/sptr_regs.sv ====
// Vendor tuning register bank of one switch port
`default_nettype none
module sptr_regs #(
	parameter bit UPSTREAM = 1'b1
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_cfg_req,
	input wire sptr_pkg::sptr_req_t i_cfg,
	output logic o_cfg_ack,
	output logic [31:0] o_cfg_rdata,
	input wire logic i_side_req,
	input wire sptr_pkg::sptr_src_t i_side_src,
	input wire sptr_pkg::sptr_req_t i_side,
	output logic o_side_ack,
	output logic [31:0] o_side_rdata,
	input wire logic i_up_link_up,
	output logic o_cfg_data_reset,
	output sptr_pkg::sptr_ctrl_t o_ctrl,
	output logic [31:0] o_phy_tuning_word,
	output logic [29:0] o_link_control,
	output logic [31:0] o_tl_control,
	output logic [6:0] o_lane_mode,
	output logic [16:0] o_phy_delta
);

	// Whole state of the bank
	typedef struct packed {
		logic [31:0] ptw;
		logic [31:0] lcw;
		logic [31:0] tlc;
		logic [31:0] pld;
		logic link_up;
		logic cfg_ack;
		logic [31:0] cfg_rdata;
		logic side_ack;
		logic [31:0] side_rdata;
		logic cfg_reset;
	} sptr_state_t;

	localparam logic [31:0] RST_LCW = UPSTREAM ?
		sptr_pkg::RST_LCW_UPSTREAM : sptr_pkg::RST_LCW_DOWNSTREAM;

	sptr_state_t state_q;
	sptr_state_t state_d;
	logic cfg_take;
	logic side_take;

	// Expand byte enables into a bit mask
	function automatic logic [31:0] sptr_be_mask(input logic [3:0] be);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction : sptr_be_mask

	// Read mux; unmapped offsets read zero
	function automatic logic [31:0] sptr_read(input sptr_state_t s,
			input logic [7:0] addr);
		unique case (addr)
			sptr_pkg::OFF_PHY_TUNING_WORD_FOUR: return s.ptw;
			sptr_pkg::OFF_LINK_CONTROL_WORD_FIVE: return s.lcw;
			sptr_pkg::OFF_TRANSACTION_LAYER_CONTROL: return s.tlc;
			sptr_pkg::OFF_PHY_LANE_AND_DELTA_PARAMS: return s.pld;
			default: return 32'h0000_0000;
		endcase
	endfunction : sptr_read

	// Bits a software configuration write may change at this offset
	function automatic logic [31:0] sptr_cfg_mask(input logic [7:0] addr);
		unique case (addr)
			sptr_pkg::OFF_LINK_CONTROL_WORD_FIVE:
				return sptr_pkg::CFG_WR_LCW;
			sptr_pkg::OFF_TRANSACTION_LAYER_CONTROL:
				return UPSTREAM ? sptr_pkg::CFG_WR_TLC_UP
					: 32'h0000_0000;
			default: return 32'h0000_0000;
		endcase
	endfunction : sptr_cfg_mask

	// Bits a sideband or EEPROM default override may change
	function automatic logic [31:0] sptr_side_mask(input logic [7:0] addr,
			input sptr_pkg::sptr_src_t src);
		logic [31:0] up;
		up = UPSTREAM ? 32'hffff_ffff : 32'h0000_0000;
		unique case (addr)
			sptr_pkg::OFF_PHY_TUNING_WORD_FOUR:
				return sptr_pkg::SB_ANY_PTW
					| (sptr_pkg::SB_UP_PTW & up);
			sptr_pkg::OFF_LINK_CONTROL_WORD_FIVE:
				return sptr_pkg::SB_ANY_LCW
					| (sptr_pkg::SB_UP_LCW & up);
			sptr_pkg::OFF_TRANSACTION_LAYER_CONTROL:
				return sptr_pkg::SB_ANY_TLC
					| (sptr_pkg::SB_UP_TLC & up)
					| ((src == sptr_pkg::SPTR_SRC_EEPROM)
					? (sptr_pkg::SB_EE_UP_TLC & up)
					: 32'h0000_0000);
			sptr_pkg::OFF_PHY_LANE_AND_DELTA_PARAMS:
				return sptr_pkg::SB_ANY_PLD
					| (sptr_pkg::SB_UP_PLD & up);
			default: return 32'h0000_0000;
		endcase
	endfunction : sptr_side_mask

	// Merge write data under a mask into one register
	function automatic logic [31:0] sptr_merge(input logic [31:0] old,
			input logic [31:0] data, input logic [31:0] m);
		return (old & ~m) | (data & m);
	endfunction : sptr_merge

	// Apply one write to the register at its offset
	function automatic sptr_state_t sptr_write(input sptr_state_t s,
			input logic [7:0] addr, input logic [31:0] data,
			input logic [31:0] m);
		sptr_state_t n;
		n = s;
		unique case (addr)
			sptr_pkg::OFF_PHY_TUNING_WORD_FOUR:
				n.ptw = sptr_merge(s.ptw, data, m);
			sptr_pkg::OFF_LINK_CONTROL_WORD_FIVE:
				n.lcw = sptr_merge(s.lcw, data, m);
			sptr_pkg::OFF_TRANSACTION_LAYER_CONTROL:
				n.tlc = sptr_merge(s.tlc, data, m);
			sptr_pkg::OFF_PHY_LANE_AND_DELTA_PARAMS:
				n.pld = sptr_merge(s.pld, data, m);
			default: n = s;
		endcase
		return n;
	endfunction : sptr_write

	// Sideband wins a tie; the configuration request just waits a cycle.
	// The ack flop blocks a second take of a request still held high.
	assign side_take = i_side_req && !state_q.side_ack;
	assign cfg_take = i_cfg_req && !state_q.cfg_ack && !side_take;

	// Next-state logic
	always_comb begin
		state_d = state_q;
		state_d.cfg_ack = 1'b0;
		state_d.side_ack = 1'b0;
		state_d.cfg_reset = 1'b0;
		state_d.link_up = i_up_link_up;
		// Default override path for SMBus, I2C and EEPROM autoload
		if (side_take) begin
			state_d.side_ack = 1'b1;
			state_d.side_rdata = sptr_read(state_q, i_side.addr);
			if (i_side.wr) begin
				state_d = sptr_write(state_d, i_side.addr, i_side.wdata,
					sptr_side_mask(i_side.addr, i_side_src)
					& sptr_be_mask(i_side.be));
			end
		end
		// Software access through configuration space
		if (cfg_take) begin
			state_d.cfg_ack = 1'b1;
			state_d.cfg_rdata = sptr_read(state_q, i_cfg.addr);
			if (i_cfg.wr) begin
				state_d = sptr_write(state_d, i_cfg.addr, i_cfg.wdata,
					sptr_cfg_mask(i_cfg.addr)
					& sptr_be_mask(i_cfg.be));
			end
		end
		// Upstream port only: link drop clears config data unless told to keep it
		if (UPSTREAM && state_q.link_up && !i_up_link_up
				&& !state_q.lcw[sptr_pkg::LCW_CFG_KEEP_BIT]) begin
			state_d.cfg_reset = 1'b1;
		end
	end

	// State register; all reset values are constants
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q.ptw <= sptr_pkg::RST_PHY_TUNING_WORD_FOUR;
			state_q.lcw <= RST_LCW;
			state_q.tlc <= sptr_pkg::RST_TRANSACTION_LAYER_CONTROL;
			state_q.pld <= sptr_pkg::RST_PHY_LANE_AND_DELTA;
			state_q.link_up <= 1'b0;
			state_q.cfg_ack <= 1'b0;
			state_q.cfg_rdata <= 32'h0000_0000;
			state_q.side_ack <= 1'b0;
			state_q.side_rdata <= 32'h0000_0000;
			state_q.cfg_reset <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	// Bus answers
	assign o_cfg_ack = state_q.cfg_ack;
	assign o_cfg_rdata = state_q.cfg_rdata;
	assign o_side_ack = state_q.side_ack;
	assign o_side_rdata = state_q.side_rdata;
	assign o_cfg_data_reset = state_q.cfg_reset;

	// Raw register fields to the PHY and MAC
	assign o_phy_tuning_word = state_q.ptw;
	assign o_link_control = state_q.lcw[29:0];
	assign o_tl_control = state_q.tlc;
	assign o_lane_mode = state_q.pld[sptr_pkg::PLD_LANE_MODE_LSB +: 7];
	assign o_phy_delta = state_q.pld[sptr_pkg::PLD_DELTA_LSB +: 17];

	// Decoded controls, each a plain flop bit except the two-bit rate_change_attempts
	assign o_ctrl.cfg_keep_on_link_down =
		state_q.lcw[sptr_pkg::LCW_CFG_KEEP_BIT];
	assign o_ctrl.rate_change_ctrl =
		state_q.lcw[sptr_pkg::LCW_RATE_CHANGE_BIT];
	assign o_ctrl.gen1_only = state_q.lcw[sptr_pkg::LCW_GEN1_ONLY_BIT];
	assign o_ctrl.mw_overpass_dis =
		state_q.tlc[sptr_pkg::TLC_MW_OVERPASS_DIS_BIT];
	assign o_ctrl.ordering_dis =
		state_q.tlc[sptr_pkg::TLC_ORDERING_DIS_BIT];
	assign o_ctrl.rate_change_attempts =
		state_q.tlc[sptr_pkg::TLC_RATE_ATTEMPT_LSB +: 2];
	assign o_ctrl.port_disable =
		state_q.tlc[sptr_pkg::TLC_PORT_DISABLE_BIT];
	assign o_ctrl.reset_select =
		state_q.tlc[sptr_pkg::TLC_RESET_SELECT_BIT];
	assign o_ctrl.retrain_on_phy_err_dis =
		state_q.tlc[sptr_pkg::TLC_RETRAIN_CTRL_LSB];

endmodule : sptr_regs
`default_nettype wire

// ==== testbench/sptr_regs_chk.sv ====
// Assertion checker bound to the tuning register bank
`default_nettype none
module sptr_chk #(
	parameter bit UPSTREAM = 1'b1
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_side_req,
	input wire logic i_up_link_up,
	input wire logic o_cfg_ack,
	input wire logic o_side_ack,
	input wire logic o_cfg_data_reset,
	input wire sptr_pkg::sptr_ctrl_t o_ctrl,
	input wire logic [31:0] o_phy_tuning_word,
	input wire logic [29:0] o_link_control,
	input wire logic [31:0] o_tl_control
);
	timeunit 1ns;
	timeprecision 1ps;
	// One clock domain, so clocking and reset are given once
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	AST_SIDE_ACK: assert property (
		i_side_req && !o_side_ack |=> o_side_ack)
		else $error("sideband request not answered");
	AST_PTW_SIDE_ONLY: assert property (
		$changed(o_phy_tuning_word) |-> o_side_ack)
		else $error("phy tuning word changed without sideband");
	AST_LCW_SIDE_ONLY: assert property (
		$changed(o_link_control) |-> o_side_ack || o_cfg_data_reset
		|| $past(o_cfg_data_reset))
		else $error("link control changed without sideband");
	AST_LINK_RESET: assert property (
		UPSTREAM && $fell(i_up_link_up) && !o_link_control[11]
		|-> ##[1:2] o_cfg_data_reset)
		else $error("no config reset on link down");
	AST_LINK_PULSE: assert property (
		o_cfg_data_reset |-> !o_link_control[11] ##1 !o_cfg_data_reset)
		else $error("config reset pulse wrong");
	AST_RATE_BITS: assert property (
		$changed(o_ctrl[8:7]) |-> o_cfg_ack || o_side_ack)
		else $error("rate bits changed without access");
	AST_CTRL_FIELDS: assert property (
		o_ctrl[6:0] == {o_tl_control[5], o_tl_control[6],
		o_tl_control[9:8], o_tl_control[10], o_tl_control[11],
		o_tl_control[16]} && o_ctrl[9] == o_link_control[11])
		else $error("control fields disagree with registers");
	AST_TLC_RSVD: assert property (
		o_tl_control[15:13] == 3'h0 && !o_tl_control[30])
		else $error("reserved bits not zero");
endmodule : sptr_chk

bind sptr_regs sptr_chk #(.UPSTREAM(UPSTREAM)) chk (.i_mclk, .i_resetn,
	.i_side_req, .i_up_link_up, .o_cfg_ack, .o_side_ack, .o_cfg_data_reset,
	.o_ctrl, .o_phy_tuning_word, .o_link_control, .o_tl_control);
`default_nettype wire

// ==== testbench/test_switch_port_tuning_registers.sv ====
// Self-checking bench for the port tuning register bank
`default_nettype none
module test_switch_port_tuning_registers;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_cfg_req = 1'b0;
	logic i_side_req = 1'b0;
	logic i_up_link_up = 1'b1;
	sptr_pkg::sptr_src_t i_side_src = sptr_pkg::SPTR_SRC_SMBUS;
	sptr_pkg::sptr_req_t i_cfg = '0;
	sptr_pkg::sptr_req_t i_side = '0;
	logic o_cfg_ack, o_side_ack, o_cfg_data_reset;
	logic [31:0] o_cfg_rdata, o_side_rdata, o_phy_tuning_word, o_tl_control;
	logic [29:0] o_link_control;
	logic [6:0] o_lane_mode;
	logic [16:0] o_phy_delta;
	sptr_pkg::sptr_ctrl_t o_ctrl;
	// Downstream copy sees the same traffic; upstream-only fields stay put
	logic dn_cfg_reset;
	logic [31:0] dn_ptw;
	logic [29:0] dn_lcw;
	logic [16:0] dn_delta;
	sptr_pkg::sptr_ctrl_t dn_ctrl;
	logic [31:0] rm [4];
	int miscompares = 0;
	int tests_run = 0;

	sptr_regs #(.UPSTREAM(1'b1)) dut (.i_mclk, .i_resetn, .i_cfg_req, .i_cfg,
		.o_cfg_ack, .o_cfg_rdata, .i_side_req, .i_side_src, .i_side,
		.o_side_ack, .o_side_rdata, .i_up_link_up, .o_cfg_data_reset,
		.o_ctrl, .o_phy_tuning_word, .o_link_control, .o_tl_control,
		.o_lane_mode, .o_phy_delta);

	// Downstream port instance, answers are ignored
	sptr_regs #(.UPSTREAM(1'b0)) dut_dn (.i_mclk, .i_resetn, .i_cfg_req,
		.i_cfg, .o_cfg_ack(), .o_cfg_rdata(), .i_side_req, .i_side_src,
		.i_side, .o_side_ack(), .o_side_rdata(), .i_up_link_up,
		.o_cfg_data_reset(dn_cfg_reset), .o_ctrl(dn_ctrl),
		.o_phy_tuning_word(dn_ptw), .o_link_control(dn_lcw),
		.o_tl_control(), .o_lane_mode(), .o_phy_delta(dn_delta));

	// Free-running core clock
	always #5 i_mclk = ~i_mclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	// Writable bits by source; of the sideband sources only the EEPROM may touch the ordering bit, and configuration writes may too
	function automatic logic [31:0] wmask(bit sb, sptr_pkg::sptr_src_t s,
		int i);
		logic [31:0] m [4];
		m = '{32'h0, sptr_pkg::CFG_WR_LCW, sptr_pkg::CFG_WR_TLC_UP, 32'h0};
		if (sb) begin
			m = '{sptr_pkg::SB_ANY_PTW | sptr_pkg::SB_UP_PTW,
				sptr_pkg::SB_ANY_LCW | sptr_pkg::SB_UP_LCW,
				sptr_pkg::SB_ANY_TLC | sptr_pkg::SB_UP_TLC |
				(s == sptr_pkg::SPTR_SRC_EEPROM ? sptr_pkg::SB_EE_UP_TLC : 32'h0),
				sptr_pkg::SB_ANY_PLD | sptr_pkg::SB_UP_PLD};
		end
		return m[i];
	endfunction : wmask

	// Registered outputs must mirror the model
	task automatic outs();
		chk(o_phy_tuning_word, rm[0]);
		chk({o_ctrl.gen1_only, o_ctrl.rate_change_ctrl, o_link_control}, rm[1]);
		chk(o_tl_control, rm[2]);
		chk({o_phy_delta, 8'h0, o_lane_mode}, rm[3]);
	endtask : outs

	// One access; the answer carries the value held before any write
	task automatic acc(input bit sb, input sptr_pkg::sptr_src_t s,
		input logic wr, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		logic [31:0] m;
		logic [31:0] q;
		int i;
		int n;
		bit ok;
		i = (int'(a) - 132) / 4;
		ok = a inside {8'h84, 8'h88, 8'h8c, 8'h90};
		@(posedge i_mclk);
		if (sb) begin
			i_side_req <= 1'b1;
			i_side <= '{wr, a, be, d};
			i_side_src <= s;
		end else begin
			i_cfg_req <= 1'b1;
			i_cfg <= '{wr, a, be, d};
		end
		n = 0;
		do begin
			@(posedge i_mclk);
			n++;
		end while ((sb ? o_side_ack : o_cfg_ack) !== 1'b1 && n < 8);
		chk({31'h0, (sb ? o_side_ack : o_cfg_ack)}, 32'h1);
		q = sb ? o_side_rdata : o_cfg_rdata;
		i_side_req <= 1'b0;
		i_cfg_req <= 1'b0;
		chk(q, ok ? rm[i] : 32'h0);
		if (ok && wr) begin
			m = wmask(sb, s, i) & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
			rm[i] = (rm[i] & ~m) | (d & m);
		end
		outs();
	endtask : acc

	// Drop the upstream link and count the config reset pulses
	task automatic link(input logic ex);
		int p = 0;
		int dp = 0;
		repeat (3) @(posedge i_mclk);
		i_up_link_up <= 1'b0;
		repeat (4) begin
			@(posedge i_mclk);
			p += o_cfg_data_reset;
			dp += dn_cfg_reset;
		end
		chk(32'(p), {31'h0, ex});
		chk(32'(dp), 32'h0);
		i_up_link_up <= 1'b1;
	endtask : link

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done

	// Watchdog: the run needs well under a thousand cycles
	initial begin
		#100000;
		miscompares++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		test_done();
	end

	// Reset values, link-down reset, refused writes, then random traffic
	initial begin
		void'($urandom(32'hf35d));
		repeat (3) @(posedge i_mclk);
		i_resetn <= 1'b1;
		rm = '{32'h0, 32'h7308_3333, 32'h0079_1894, 32'h0000_8000};
		@(posedge i_mclk);
		outs();
		chk({dn_ctrl.gen1_only, dn_ctrl.rate_change_ctrl, dn_lcw},
			32'h3308_3333);
		link(1'b1);
		acc(1, sptr_pkg::SPTR_SRC_I2C, 1, 8'h88, 4'hf, rm[1] | 32'h800);
		link(1'b0);
		i_resetn <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_resetn <= 1'b1;
		rm = '{32'h0, 32'h7308_3333, 32'h0079_1894, 32'h0000_8000};
		@(posedge i_mclk);
		outs();
		acc(0, sptr_pkg::SPTR_SRC_SMBUS, 1, 8'h84, 4'hf, '1);
		acc(0, sptr_pkg::SPTR_SRC_SMBUS, 1, 8'h88, 4'hf, '1);
		acc(0, sptr_pkg::SPTR_SRC_SMBUS, 1, 8'h8c, 4'hf, '1);
		acc(1, sptr_pkg::SPTR_SRC_SMBUS, 1, 8'h8c, 4'hf, '1);
		acc(1, sptr_pkg::SPTR_SRC_EEPROM, 1, 8'h8c, 4'hf, 32'h40);
		acc(1, sptr_pkg::SPTR_SRC_I2C, 1, 8'h90, 4'h9, '1);
		acc(1, sptr_pkg::SPTR_SRC_SMBUS, 1, 8'h94, 4'hf, '1);
		repeat (120) begin
			acc($urandom % 2, sptr_pkg::sptr_src_t'($urandom % 3), $urandom % 2,
				8'h80 + 8'(4 * ($urandom % 6)), 4'($urandom), $urandom);
		end
		chk(dn_ptw, 32'h0);
		chk({2'h0, dn_lcw}, 32'h3308_3333);
		chk({15'h0, dn_delta}, 32'h1);
		test_done();
	end
endmodule : test_switch_port_tuning_registers
`default_nettype wire
